// file: bench/host_model.sv
// host side of the serial link: frames, command bytes and data bytes
// assumes i_mclk from the bench; each sclk phase lasts four mclk cycles
`timescale 1ns/10ps
`default_nettype none
module host_model
    import meter_pkg::*;
(
    input  wire logic       i_mclk,
    input  wire logic       i_dout,
    output var serial_pins_t o_pins
);
    initial o_pins = 3'b100;
    // one byte msb first; din held across the fall that samples it
    task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            repeat (4) @(posedge i_mclk);
            #1 o_pins.sclk = 1'b1;
            o_pins.din = tx[i];
            repeat (4) @(posedge i_mclk);
            #1 rx[i] = i_dout;
            o_pins.sclk = 1'b0;
        end
    endtask : shift
    // command byte first, then n data bytes, top byte first
    task automatic xfer(input logic [7:0] cmd, input logic [23:0] wd, input int n, output logic [23:0] rd);
        logic [7:0] b;
        rd = '0;
        @(posedge i_mclk) #1 o_pins.cs_n = 1'b0;
        shift(cmd, b);
        for (int k = n - 1; k >= 0; k--) begin
            shift(wd[8*k +: 8], b);
            rd = {rd[15:0], b};
        end
        repeat (4) @(posedge i_mclk);
        #1 o_pins.cs_n = 1'b1;
        o_pins.din = ~o_pins.din;
        // idle gap well over 1 us before the next command
        repeat (50) @(posedge i_mclk);
    endtask : xfer
endmodule : host_model
`default_nettype wire

// file: bench/metering_register_access_bench.sv
// self-checking bench for the metering register access block
// assumes host_model on the serial pins; datapath strobes come from here
`timescale 1ns/10ps
`default_nettype none
module metering_register_access_bench;
    import meter_pkg::*;
    logic          i_mclk = 1'b0;
    logic          i_rst_n = 1'b0;
    serial_pins_t  pins;
    logic          dout, oe, pv, hc, prv, tv, sv, lcd;
    phase_power_t  act, app;
    phase_period_t per;
    logic [7:0]    temp;
    adc_set_t      adc;
    logic [31:0]   acc, acc2;
    logic [23:0]   rd, e;
    integer        failures = 0, samples_checked = 0, seed = 83115, cyc = 0, dones = 0, base;

    always #12.5 i_mclk = ~i_mclk;
    // cycle ceiling and count of line window closures
    always @(posedge i_mclk) begin
        cyc++;
        if (lcd === 1'b1) dones++;
        if (cyc == 40000) begin
            failures++;
            tally_and_finish();
        end
    end

    metering_register_access dut_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_serial(pins), .o_dout(dout),
        .o_dout_oe(oe), .i_power_valid(pv), .i_active_power(act), .i_apparent_power(app), .i_half_cycle(hc),
        .i_period_valid(prv), .i_period(per), .i_temp_valid(tv), .i_temperature(temp), .i_sample_valid(sv),
        .i_adc_samples(adc), .o_line_cycle_done(lcd));
    host_model host_u (.i_mclk(i_mclk), .i_dout(dout), .o_pins(pins));

    task automatic check(input string w, input logic [23:0] seen, input logic [23:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", w, exp, seen);
        end
    endtask : check
    // read command has bit 7 and bit 6 low
    task automatic rdchk(input string w, input logic [5:0] a, input int n, input logic [23:0] exp);
        host_u.xfer({2'b00, a}, 24'h0, n, rd);
        check(w, rd, exp);
        check("dout_oe", 24'(oe), 24'h0);
    endtask : rdchk
    // write command has bit 7 high, bit 6 low
    task automatic wr(input logic [5:0] a, input logic [23:0] v, input int n);
        logic [23:0] unused;
        host_u.xfer({2'b10, a}, v, n, unused);
    endtask : wr
    task automatic pulse(ref logic s);
        @(posedge i_mclk) #1 s = 1'b1;
        @(posedge i_mclk) #1 s = 1'b0;
    endtask : pulse
    // random positive power on all phases, summed as the default modes add them
    task automatic feed();
        #1 acc = '0;
        acc2 = '0;
        for (int k = 0; k < 5; k++) begin
            act = 48'({$random(seed), $random(seed)}) & 48'h3FFF3FFF3FFF;
            app = 48'({$random(seed), $random(seed)}) & 48'h3FFF3FFF3FFF;
            acc += act.a + act.b + act.c;
            acc2 += app.a + app.b + app.c;
            pulse(pv);
        end
    endtask : feed
    function automatic logic [14:0] pick(input phase_period_t p, input int m);
        pick = (m == 1) ? p.b : (m == 2) ? p.c : p.a;
    endfunction : pick
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish

    initial begin
        {pv, hc, prv, tv, sv} = '0;
        {act, app, per, temp, adc} = '0;
        repeat (5) @(posedge i_mclk);
        #1 i_rst_n = 1'b1;
        // reset contents, reserved and unmapped reads
        rdchk("meas_mode", ADDR_MEAS_MODE, 1, 24'(MEAS_MODE_RST));
        rdchk("act_mode", ADDR_ACT_MODE, 1, 24'(ACT_MODE_RST));
        rdchk("half_cycles", ADDR_HALF_CYCLES, 2, 24'(HALF_CYCLES_RST));
        rdchk("reserved", ADDR_RESERVED, 1, 24'h000000);
        rdchk("unmapped", 6'h3F, 1, 24'h000000);
        // writable setting and writes that must be discarded
        e = 24'($random(seed));
        wr(ADDR_HALF_CYCLES, e, 2);
        rdchk("half_cycles", ADDR_HALF_CYCLES, 2, {8'h00, e[15:0]});
        wr(ADDR_RESERVED, e, 1);
        wr(ADDR_ACT_ENERGY, e, 3);
        rdchk("act_energy", ADDR_ACT_ENERGY, 3, 24'h000000);
        $display("test access done");
        // latest results, channel chosen by the mode settings
        for (int m = 0; m < 6; m++) begin
            #1 temp = 8'($random(seed));
            per = 45'({$random(seed), $random(seed)});
            for (int j = 0; j < 6; j++) adc[j] = 24'($random(seed));
            wr(ADDR_WAVE_MODE, 24'(m), 1);
            wr(ADDR_MEAS_MODE, 24'h70 + 24'(m % 4), 1);
            pulse(tv);
            pulse(prv);
            pulse(sv);
            wr(ADDR_TEMP, {16'h0, ~temp}, 1);
            rdchk("temp", ADDR_TEMP, 1, {16'h0, temp});
            rdchk("period", ADDR_PERIOD, 2, {9'h0, pick(per, m % 4)});
            rdchk("wave", ADDR_WAVE, 3, adc[m]);
        end
        $display("test results done");
        // plain reads keep the total, clearing reads empty it
        feed();
        rdchk("act_energy", ADDR_ACT_ENERGY, 3, acc[31:8]);
        rdchk("act_energy", ADDR_ACT_ENERGY, 3, acc[31:8]);
        rdchk("act_clear", ADDR_ACT_CLEAR, 3, acc[31:8]);
        rdchk("act_energy", ADDR_ACT_ENERGY, 3, 24'h0);
        rdchk("app_energy", ADDR_APP_ENERGY, 3, acc2[31:8]);
        rdchk("app_clear", ADDR_APP_CLEAR, 3, acc2[31:8]);
        rdchk("app_energy", ADDR_APP_ENERGY, 3, 24'h0);
        $display("test energy done");
        // two half cycles per window once aligned to a closure
        wr(ADDR_HALF_CYCLES, 24'h2, 2);
        for (int k = 0; k < 4 && dones == 0; k++) begin
            pulse(hc);
            repeat (3) @(posedge i_mclk);
        end
        base = dones;
        feed();
        pulse(hc);
        repeat (3) @(posedge i_mclk);
        check("line_done", 24'(dones), 24'(base));
        pulse(hc);
        repeat (3) @(posedge i_mclk);
        check("line_done", 24'(dones), 24'(base + 1));
        rdchk("line_act", ADDR_LINE_ACT, 3, acc[31:8]);
        rdchk("line_app", ADDR_LINE_APP, 3, acc2[31:8]);
        $display("test line done");
        tally_and_finish();
    end
endmodule : metering_register_access_bench
`default_nettype wire

// file: hw/meter_pkg.sv
// constants, types and helper functions for the metering register access block
// assumes one 40 MHz clock domain; serial pins arrive already synchronous to it
// Functional notes
// - 8-bit write-only command register, never read back
// - command byte precedes every data transfer
// - command bits 5..0 address target register
// - command bit 7 high means write follows
// - command bit 7 low means read follows
// - address 01h: 24-bit active energy, not cleared
// - active accumulator holds 88 s full scale
// - active mode bits 7..3 choose input combination
// - address 02h: active energy, cleared after read
// - address 03h: active energy over half cycles
// - active mode bits 2..0 choose line combination
// - address 04h: apparent energy, mode bits 7..3
// - address 05h: apparent energy, cleared after read
// - address 06h: line apparent energy, bits 2..0
// - address 07h: 15-bit period, channel by mode
// - address 08h: 8-bit latest temperature result
// - address 09h: 24-bit waveform sample register
// - waveform mode bits 2..0 pick input
// - read captures whole register at once
// - data MSB byte first, right justified
// - register 13h sets half cycle span
package meter_pkg;

    // register addresses
    localparam logic [5:0] ADDR_RESERVED    = 6'h00;
    localparam logic [5:0] ADDR_ACT_ENERGY  = 6'h01;
    localparam logic [5:0] ADDR_ACT_CLEAR   = 6'h02;
    localparam logic [5:0] ADDR_LINE_ACT    = 6'h03;
    localparam logic [5:0] ADDR_APP_ENERGY  = 6'h04;
    localparam logic [5:0] ADDR_APP_CLEAR   = 6'h05;
    localparam logic [5:0] ADDR_LINE_APP    = 6'h06;
    localparam logic [5:0] ADDR_PERIOD      = 6'h07;
    localparam logic [5:0] ADDR_TEMP        = 6'h08;
    localparam logic [5:0] ADDR_WAVE        = 6'h09;
    localparam logic [5:0] ADDR_MEAS_MODE   = 6'h0B;
    localparam logic [5:0] ADDR_WAVE_MODE   = 6'h0C;
    localparam logic [5:0] ADDR_ACT_MODE    = 6'h0D;
    localparam logic [5:0] ADDR_APP_MODE    = 6'h0E;
    localparam logic [5:0] ADDR_HALF_CYCLES = 6'h13;

    // command byte fields
    localparam int CMD_WRITE_BIT = 7;
    localparam int CMD_ADDR_MSB  = 5;

    // reset values
    localparam logic [7:0]  MEAS_MODE_RST   = 8'h70;
    localparam logic [7:0]  WAVE_MODE_RST   = 8'h00;
    localparam logic [7:0]  ACT_MODE_RST    = 8'h3F;
    localparam logic [7:0]  APP_MODE_RST    = 8'h3F;
    localparam logic [15:0] HALF_CYCLES_RST = 16'hFFFF;
    localparam logic [23:0] RESULT_RST      = 24'h000000;
    localparam logic [31:0] ACC_RST         = 32'h00000000;

    // widths; 8 guard bits below the visible 24 give the 88 s headroom
    localparam int ENERGY_W      = 24;
    localparam int ACC_W         = 32;
    localparam int ACC_FRAC_BITS = 8;
    localparam int POWER_W       = 16;
    localparam int PERIOD_W      = 15;
    localparam int TEMP_W        = 8;
    localparam int SAMPLE_W      = 24;

    typedef struct packed {
        logic signed [POWER_W-1:0] a;
        logic signed [POWER_W-1:0] b;
        logic signed [POWER_W-1:0] c;
    } phase_power_t;

    typedef struct packed {
        logic [PERIOD_W-1:0] a;
        logic [PERIOD_W-1:0] b;
        logic [PERIOD_W-1:0] c;
    } phase_period_t;

    typedef logic [5:0][SAMPLE_W-1:0] adc_set_t;

    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic din;
    } serial_pins_t;

    typedef enum logic [1:0] {ST_CMD, ST_WRITE, ST_READ} xfer_state_t;

    // bytes on the wire for each address; unmapped reads give one zero byte
    function automatic logic [1:0] reg_bytes(input logic [5:0] addr);
        case (addr)
            ADDR_ACT_ENERGY, ADDR_ACT_CLEAR, ADDR_LINE_ACT, ADDR_APP_ENERGY,
            ADDR_APP_CLEAR, ADDR_LINE_APP, ADDR_WAVE:  reg_bytes = 2'd3;
            ADDR_PERIOD, ADDR_HALF_CYCLES:             reg_bytes = 2'd2;
            default:                                   reg_bytes = 2'd1;
        endcase
    endfunction : reg_bytes

    function automatic logic reg_writable(input logic [5:0] addr);
        reg_writable = (addr == ADDR_MEAS_MODE) || (addr == ADDR_WAVE_MODE) || (addr == ADDR_ACT_MODE) ||
                       (addr == ADDR_APP_MODE) || (addr == ADDR_HALF_CYCLES);
    endfunction : reg_writable

    // sel[2:0] enable phases a,b,c; sel[4:3]==01 subtracts phase b
    function automatic logic signed [ACC_W-1:0] combine(input phase_power_t p, input logic [4:0] sel);
        logic signed [ACC_W-1:0] sum;
        sum = '0;
        if (sel[0]) sum = sum + ACC_W'(p.a);
        if (sel[1]) sum = (sel[4:3] == 2'b01) ? sum - ACC_W'(p.b) : sum + ACC_W'(p.b);
        if (sel[2]) sum = sum + ACC_W'(p.c);
        combine = sum;
    endfunction : combine

endpackage : meter_pkg

// file: hw/metering_register_access.sv
// register access front end and result registers of the energy metering core
// assumes measurement samples and strobes come from the datapath on i_mclk
`timescale 1ns/10ps
`default_nettype none
module metering_register_access
    import meter_pkg::*;
(
    input  wire logic          i_mclk,
    input  wire logic          i_rst_n,
    input  wire serial_pins_t  i_serial,
    output logic               o_dout,
    output logic               o_dout_oe,
    input  wire logic          i_power_valid,
    input  wire phase_power_t  i_active_power,
    input  wire phase_power_t  i_apparent_power,
    input  wire logic          i_half_cycle,
    input  wire logic          i_period_valid,
    input  wire phase_period_t i_period,
    input  wire logic          i_temp_valid,
    input  wire logic [7:0]    i_temperature,
    input  wire logic          i_sample_valid,
    input  wire adc_set_t      i_adc_samples,
    output logic               o_line_cycle_done
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    xfer_state_t state_reg;
    logic [7:0]  cmd_reg;
    logic [1:0]  byte_cnt_reg;
    logic [15:0] wr_data_reg;
    logic [23:0] snap_reg;
    logic [7:0]  meas_mode_reg;
    logic [7:0]  wave_mode_reg;
    logic [7:0]  act_mode_reg;
    logic [7:0]  app_mode_reg;
    logic [15:0] half_cycles_reg;
    logic [31:0] act_acc_reg;
    logic [31:0] app_acc_reg;
    logic [31:0] line_act_acc_reg;
    logic [31:0] line_app_acc_reg;
    logic [23:0] line_act_reg;
    logic [23:0] line_app_reg;
    logic [15:0] half_cnt_reg;
    logic [14:0] period_reg;
    logic [7:0]  temp_reg;
    logic [23:0] wave_reg;

    logic [7:0]  rx_byte;
    logic        rx_done;
    logic [5:0]  rx_addr;
    logic [5:0]  cur_addr;
    logic        last_byte;
    logic        wr_commit;
    logic        rd_done;
    logic        line_done;
    logic [23:0] wr_word;
    logic [23:0] read_value;
    logic [31:0] act_inc;
    logic [31:0] app_inc;
    logic [31:0] line_act_inc;
    logic [31:0] line_app_inc;

    serial_shifter u_shifter (
        .i_mclk     (i_mclk),
        .i_rst_n    (i_rst_n),
        .i_pins     (i_serial),
        .i_tx_load  (state_reg == ST_CMD && rx_done && !rx_byte[CMD_WRITE_BIT]),
        .i_tx_word  (read_value),
        .i_tx_bytes (reg_bytes(rx_addr)),
        .i_tx_en    (state_reg == ST_READ),
        .o_rx_byte  (rx_byte),
        .o_rx_done  (rx_done),
        .o_dout     (o_dout),
        .o_dout_oe  (o_dout_oe)
    );

    // transfer qualifiers
    assign rx_addr   = rx_byte[CMD_ADDR_MSB:0];
    assign cur_addr  = cmd_reg[CMD_ADDR_MSB:0];
    assign last_byte = (byte_cnt_reg == reg_bytes(cur_addr) - 2'd1);
    assign wr_commit = (state_reg == ST_WRITE) && rx_done && last_byte;
    assign rd_done   = (state_reg == ST_READ) && rx_done && last_byte;
    assign wr_word   = {wr_data_reg, rx_byte};

    // readback mux; the command register has no address and never reads back
    always_comb begin
        case (rx_addr)
            ADDR_ACT_ENERGY, ADDR_ACT_CLEAR: read_value = act_acc_reg[ACC_W-1:ACC_FRAC_BITS];
            ADDR_LINE_ACT:    read_value = line_act_reg;
            ADDR_APP_ENERGY, ADDR_APP_CLEAR: read_value = app_acc_reg[ACC_W-1:ACC_FRAC_BITS];
            ADDR_LINE_APP:    read_value = line_app_reg;
            ADDR_PERIOD:      read_value = {9'h000, period_reg};
            ADDR_TEMP:        read_value = {16'h0000, temp_reg};
            ADDR_WAVE:        read_value = wave_reg;
            ADDR_MEAS_MODE:   read_value = {16'h0000, meas_mode_reg};
            ADDR_WAVE_MODE:   read_value = {16'h0000, wave_mode_reg};
            ADDR_ACT_MODE:    read_value = {16'h0000, act_mode_reg};
            ADDR_APP_MODE:    read_value = {16'h0000, app_mode_reg};
            ADDR_HALF_CYCLES: read_value = {8'h00, half_cycles_reg};
            default:          read_value = RESULT_RST;
        endcase
    end

    // command / data sequencing; chip select high returns to command mode
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n || i_serial.cs_n) begin
            state_reg    <= ST_CMD;
            byte_cnt_reg <= 2'd0;
            wr_data_reg  <= 16'h0000;
            if (!i_rst_n) cmd_reg <= 8'h00;
        end else begin
            case (state_reg)
                ST_CMD: begin
                    if (rx_done) begin
                        cmd_reg      <= rx_byte;
                        byte_cnt_reg <= 2'd0;
                        state_reg    <= rx_byte[CMD_WRITE_BIT] ? ST_WRITE : ST_READ;
                    end
                end
                ST_WRITE: begin
                    if (rx_done) begin
                        wr_data_reg  <= {wr_data_reg[7:0], rx_byte};
                        byte_cnt_reg <= byte_cnt_reg + 2'd1;
                        if (last_byte) state_reg <= ST_CMD;
                    end
                end
                ST_READ: begin
                    if (rx_done) begin
                        byte_cnt_reg <= byte_cnt_reg + 2'd1;
                        if (last_byte) state_reg <= ST_CMD;
                    end
                end
                default: state_reg <= ST_CMD;
            endcase
        end
    end

    // whole register frozen when the read command lands
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n)                               snap_reg <= RESULT_RST;
        else if (state_reg == ST_CMD && rx_done)    snap_reg <= read_value;
    end

    // writable settings; other addresses ignore writes
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            meas_mode_reg   <= MEAS_MODE_RST;
            wave_mode_reg   <= WAVE_MODE_RST;
            act_mode_reg    <= ACT_MODE_RST;
            app_mode_reg    <= APP_MODE_RST;
            half_cycles_reg <= HALF_CYCLES_RST;
        end else if (wr_commit && reg_writable(cur_addr)) begin
            case (cur_addr)
                ADDR_MEAS_MODE:   meas_mode_reg   <= wr_word[7:0];
                ADDR_WAVE_MODE:   wave_mode_reg   <= wr_word[7:0];
                ADDR_ACT_MODE:    act_mode_reg    <= wr_word[7:0];
                ADDR_APP_MODE:    app_mode_reg    <= wr_word[7:0];
                ADDR_HALF_CYCLES: half_cycles_reg <= wr_word[15:0];
                default:          half_cycles_reg <= half_cycles_reg;
            endcase
        end
    end

    // per-sample energy increments chosen by the mode settings
    always_comb begin
        act_inc      = i_power_valid ? combine(i_active_power, act_mode_reg[7:3]) : ACC_RST;
        app_inc      = i_power_valid ? combine(i_apparent_power, app_mode_reg[7:3]) : ACC_RST;
        line_act_inc = i_power_valid ? combine(i_active_power, {2'b00, act_mode_reg[2:0]}) : ACC_RST;
        line_app_inc = i_power_valid ? combine(i_apparent_power, {2'b00, app_mode_reg[2:0]}) : ACC_RST;
    end

    // total accumulators; guard bits give the overflow headroom
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            act_acc_reg <= ACC_RST;
            app_acc_reg <= ACC_RST;
        end else begin
            if (rd_done && cur_addr == ADDR_ACT_CLEAR)
                act_acc_reg <= act_acc_reg - {snap_reg, 8'h00} + act_inc;
            else
                act_acc_reg <= act_acc_reg + act_inc;
            if (rd_done && cur_addr == ADDR_APP_CLEAR)
                app_acc_reg <= app_acc_reg - {snap_reg, 8'h00} + app_inc;
            else
                app_acc_reg <= app_acc_reg + app_inc;
        end
    end

    // half cycle window; zero behaves as one
    assign line_done = i_half_cycle && ({1'b0, half_cnt_reg} + 17'h00001 >= {1'b0, half_cycles_reg});

    // line-cycle accumulation and latch at the end of each window
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            half_cnt_reg      <= 16'h0000;
            line_act_acc_reg  <= ACC_RST;
            line_app_acc_reg  <= ACC_RST;
            line_act_reg      <= RESULT_RST;
            line_app_reg      <= RESULT_RST;
            o_line_cycle_done <= 1'b0;
        end else begin
            o_line_cycle_done <= line_done;
            if (line_done) begin
                half_cnt_reg     <= 16'h0000;
                line_act_reg     <= line_act_acc_reg[ACC_W-1:ACC_FRAC_BITS];
                line_app_reg     <= line_app_acc_reg[ACC_W-1:ACC_FRAC_BITS];
                line_act_acc_reg <= line_act_inc;
                line_app_acc_reg <= line_app_inc;
            end else begin
                if (i_half_cycle) half_cnt_reg <= half_cnt_reg + 16'h0001;
                line_act_acc_reg <= line_act_acc_reg + line_act_inc;
                line_app_acc_reg <= line_app_acc_reg + line_app_inc;
            end
        end
    end

    // period, temperature and waveform captures
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            period_reg <= 15'h0000;
            temp_reg   <= 8'h00;
            wave_reg   <= RESULT_RST;
        end else begin
            if (i_period_valid) begin
                case (meas_mode_reg[1:0])
                    2'd1:    period_reg <= i_period.b;
                    2'd2:    period_reg <= i_period.c;
                    default: period_reg <= i_period.a;
                endcase
            end
            if (i_temp_valid) temp_reg <= i_temperature;
            if (i_sample_valid && wave_mode_reg[2:0] < 3'd6)
                wave_reg <= i_adc_samples[wave_mode_reg[2:0]];
        end
    end

    // checks
    abort_cmd_a: assert property (i_serial.cs_n |=> state_reg == ST_CMD)
        else $error("chip select high did not return to command mode");
    write_decode_a: assert property (state_reg == ST_CMD && rx_done && rx_byte[7] && !i_serial.cs_n
        |=> state_reg == ST_WRITE)
        else $error("write command not decoded");
    read_decode_a: assert property (state_reg == ST_CMD && rx_done && !rx_byte[7] && !i_serial.cs_n
        |=> state_reg == ST_READ ##1 o_dout_oe == 1'b0)
        else $error("read command not decoded");
    addr_latch_a: assert property (state_reg == ST_CMD && rx_done && !i_serial.cs_n
        |=> cmd_reg[5:0] == $past(rx_byte[5:0]))
        else $error("command address not latched");
    ro_protect_a: assert property (wr_commit && !reg_writable(cur_addr)
        |=> $stable(act_mode_reg) && $stable(half_cycles_reg) && $stable(wave_mode_reg))
        else $error("write to read-only address changed a setting");
    snap_hold_a: assert property (state_reg == ST_READ && $past(state_reg) == ST_READ |-> $stable(snap_reg))
        else $error("read snapshot changed during transfer");
    act_clear_a: assert property (rd_done && cur_addr == ADDR_ACT_CLEAR && !i_power_valid
        |=> act_acc_reg == $past(act_acc_reg) - {$past(snap_reg), 8'h00})
        else $error("active energy not cleared after read");
    act_keep_a: assert property (rd_done && cur_addr == ADDR_ACT_ENERGY && !i_power_valid
        |=> $stable(act_acc_reg))
        else $error("plain active energy read disturbed accumulator");
    app_clear_a: assert property (rd_done && cur_addr == ADDR_APP_CLEAR && !i_power_valid
        |=> app_acc_reg == $past(app_acc_reg) - {$past(snap_reg), 8'h00})
        else $error("apparent energy not cleared after read");
    line_latch_a: assert property (line_done |=> line_act_reg == $past(line_act_acc_reg[31:8])
        && o_line_cycle_done)
        else $error("line energy not latched at window end");
    wave_sel_a: assert property (i_sample_valid && wave_mode_reg[2:0] == 3'd0
        |=> wave_reg == $past(i_adc_samples[0]))
        else $error("waveform source selection wrong");

    // data phase and transfer end checks
    oe_phase_a: assert property (o_dout_oe |-> state_reg == ST_READ || $past(state_reg) == ST_READ)
        else $error("dout driven outside a read");
    xfer_end_a: assert property (rd_done || wr_commit |=> state_reg == ST_CMD)
        else $error("no return to command mode");

    // register content checks
    write_land_a: assert property (wr_commit && cur_addr == ADDR_HALF_CYCLES
        |=> half_cycles_reg == $past(wr_word[15:0]))
        else $error("half cycle count write lost");
    app_keep_a: assert property (rd_done && cur_addr == ADDR_APP_ENERGY && !i_power_valid
        |=> $stable(app_acc_reg))
        else $error("plain apparent energy read disturbed accumulator");
    period_sel_a: assert property (i_period_valid && meas_mode_reg[1:0] == 2'd1
        |=> period_reg == $past(i_period.b))
        else $error("period channel selection wrong");
    temp_latch_a: assert property (i_temp_valid
        |=> temp_reg == $past(i_temperature))
        else $error("temperature result not latched");
    half_hold_a: assert property (!i_half_cycle
        |=> $stable(half_cnt_reg))
        else $error("half cycle count moved without a crossing");

    // cover points for the main scenarios
    write_seen_c: cover property (wr_commit && cur_addr == ADDR_HALF_CYCLES);
    read_seen_c:  cover property (rd_done && cur_addr == ADDR_ACT_ENERGY);
    clear_seen_c: cover property (rd_done && cur_addr == ADDR_APP_CLEAR);
    line_seen_c:  cover property (line_done);
    wave_seen_c:  cover property (i_sample_valid && wave_mode_reg[2:0] == 3'd5);
endmodule : metering_register_access
`default_nettype wire

// file: hw/serial_shifter.sv
// serial byte shifter: samples din on sclk falls, drives dout on sclk rises
// assumes sclk, din and cs_n are synchronous to i_mclk and far slower than it
`timescale 1ns/10ps
`default_nettype none
module serial_shifter
    import meter_pkg::*;
(
    input  wire logic          i_mclk,
    input  wire logic          i_rst_n,
    input  wire serial_pins_t  i_pins,
    input  wire logic          i_tx_load,
    input  wire logic [23:0]   i_tx_word,
    input  wire logic [1:0]    i_tx_bytes,
    input  wire logic          i_tx_en,
    output logic [7:0]         o_rx_byte,
    output logic               o_rx_done,
    output logic               o_dout,
    output logic               o_dout_oe
);
    logic        sclk_d_reg;
    logic [6:0]  rx_shift_reg;
    logic [2:0]  bit_cnt_reg;
    logic [23:0] tx_reg;
    logic        sclk_rise;
    logic        sclk_fall;

    // edge detection on the sampled serial clock
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) sclk_d_reg <= 1'b0;
        else          sclk_d_reg <= i_pins.sclk;
    end
    assign sclk_rise = i_pins.sclk && !sclk_d_reg;
    assign sclk_fall = !i_pins.sclk && sclk_d_reg;

    // receive; chip select high drops a partial byte
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n || i_pins.cs_n) begin
            rx_shift_reg <= 7'h00;
            bit_cnt_reg  <= 3'h0;
            o_rx_done    <= 1'b0;
            o_rx_byte    <= 8'h00;
        end else begin
            o_rx_done <= 1'b0;
            if (sclk_fall) begin
                rx_shift_reg <= {rx_shift_reg[5:0], i_pins.din};
                bit_cnt_reg  <= bit_cnt_reg + 3'h1;
                if (bit_cnt_reg == 3'h7) begin
                    o_rx_done <= 1'b1;
                    o_rx_byte <= {rx_shift_reg, i_pins.din};
                end
            end
        end
    end

    // transmit, most significant byte first with the word right justified
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            tx_reg    <= 24'h000000;
            o_dout    <= 1'b0;
            o_dout_oe <= 1'b0;
        end else if (i_tx_load) begin
            case (i_tx_bytes)
                2'd1:    tx_reg <= {i_tx_word[7:0], 16'h0000};
                2'd2:    tx_reg <= {i_tx_word[15:0], 8'h00};
                default: tx_reg <= i_tx_word;
            endcase
        end else if (!i_tx_en || i_pins.cs_n) begin
            o_dout_oe <= 1'b0;
        end else if (sclk_rise) begin
            o_dout    <= tx_reg[23];
            tx_reg    <= {tx_reg[22:0], 1'b0};
            o_dout_oe <= 1'b1;
        end
    end
endmodule : serial_shifter
`default_nettype wire
